// File: rtl/pcrc_top.sv
// PLL configuration, clock dividers, reset sequencing and watchdog
//
// Behaviour
// R01: Core ratio from multiplier, input scale, post scaler
// R02: Software keeps fields and VCO within limits
// R03: Core PLL register write updates core fields
// R04: Software reprograms core PLL after boot
// R05: Fixed reference tick for software timing
// R06: Core and switch clocks divide independently
// R07: Low power bypasses PLLs, reference slows
// R08: App clock drives pin and tile port
// R09: App output divider in even steps
// R10: Select flag picks secondary PLL input
// R11: Fractional period bumps multiplier by one
// R12: Fraction set by cycle and minor counts
// R13: Software keeps minor below cycle count
// R14: Oscillator running before reset release
// R15: Power-on reset defines all state
// R16: Reset pin resets chip, boot follows
// R17: Five TCK with TMS high resets JTAG
// R18: Soft reset keeps PLL settings
// R19: Watchdog on oscillator resets chip
// R20: 12-bit timer with 16-bit prescaler
// R21: System delays reset pin for flash
// R22: Kick reloads full watchdog time-out
// R23: Fraction disabled keeps multiplier unchanged
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "pcrc_cfg.svh"
module pcrc_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic osc_input,
  input wire logic ext_reset_b,
  input wire logic tck,
  input wire logic tms,
  output logic [5:0] core_input_scale,
  output logic [12:0] core_loop_multiplier,
  output logic [2:0] core_post_scaler,
  output logic [5:0] app_input_scale,
  output logic [12:0] app_loop_multiplier,
  output logic [2:0] app_post_scaler,
  output logic app_input_sel,
  output logic pll_low_power,
  output logic core_clk_tick,
  output logic switch_clk_tick,
  output logic ref_clk_tick,
  output logic app_clock_pin,
  output logic app_clock_port,
  output logic chip_reset_b,
  output logic pin_pulldown_en,
  output logic boot_start,
  output logic jtag_idle_reset
);
  localparam int BOOT_MIN = 1;
  localparam int BOOT_MAX = 24;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [1:0] osc_s, ext_s, tck_s, tms_s; // Two-stage samplers
  logic osc_d; // Previous oscillator level
  logic tck_d; // Previous TCK level
  wire osc_tick = osc_s[1] & ~osc_d; // Oscillator rising edge
  wire tck_rise = tck_s[1] & ~tck_d; // TCK rising edge
  wire ext_low = ~ext_s[1]; // Reset pin asserted

  // Sample asynchronous pins
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      osc_s <= 2'h0;
      ext_s <= 2'h3;
      tck_s <= 2'h0;
      tms_s <= 2'h0;
      osc_d <= 1'b0;
      tck_d <= 1'b0;
    end else if (clk_en) begin
      osc_s <= {osc_s[0], osc_input};
      ext_s <= {ext_s[0], ext_reset_b};
      tck_s <= {tck_s[0], tck};
      tms_s <= {tms_s[0], tms};
      osc_d <= osc_s[1];
      tck_d <= tck_s[1];
    end
  end

  // ********************************
  // Register storage and decode
  // ********************************
  logic [31:0] app_div_reg; // App divider and enable
  logic [15:0] clk_div_reg; // Core and switch dividers
  logic cfg_fresh; // Watchdog set-up written last cycle
  logic [12:0] app_mult; // Secondary loop multiplier
  logic [7:0] minor_count, cycle_count; // Fraction setting
  logic frac_en; // Fraction enable
  logic [31:0] wdog_cfg; // Watchdog set-up
  logic wdog_fired; // Sticky watchdog event
  logic wdog_expire; // Watchdog pulse
  logic [7:0] frac_cnt; // Position in fraction period
  logic keep_pll; // Hold came from soft reset
  logic [4:0] seq_cnt; // Sequencer delay
  logic [2:0] tms_cnt; // TCK edges with TMS high
  pcrc_pkg::pcrc_seq_t seq, next_seq; // Reset sequencer

  wire wr_core = wr_en && addr == `PCRC_CORE_PLL;
  wire wr_cdiv = wr_en && addr == `PCRC_CLK_DIV;
  wire wr_app = wr_en && addr == `PCRC_APP_PLL;
  wire wr_adiv = wr_en && addr == `PCRC_APP_DIV;
  wire wr_frac = wr_en && addr == `PCRC_FRAC;
  wire wr_wcfg = wr_en && addr == `PCRC_WDOG_CFG;
  wire wr_kick = wr_en && addr == `PCRC_WDOG_KICK;
  wire wr_stat = wr_en && addr == `PCRC_STATUS;
  wire soft_req = wr_core && wr_data[`PCRC_SOFT_BIT];
  wire in_hold = seq == pcrc_pkg::SEQ_HOLD; // Chip held in reset
  wire pll_clear = in_hold && !keep_pll; // Full reset clears PLL
  wire [31:0] core_word = {9'h000, pll_low_power, core_post_scaler,
    core_loop_multiplier, core_input_scale};
  wire [31:0] app_word = {8'h00, app_input_sel, 1'b0, app_post_scaler,
    app_mult, app_input_scale};
  wire [31:0] frac_word = {frac_en, 15'h0000, cycle_count, minor_count};
  wire [31:0] stat_word = {29'h0, frac_cnt <= minor_count, keep_pll,
    wdog_fired};
  wire [31:0] rd_mux =
    addr == `PCRC_CORE_PLL ? core_word :
    addr == `PCRC_CLK_DIV ? {16'h0000, clk_div_reg} :
    addr == `PCRC_APP_PLL ? app_word :
    addr == `PCRC_APP_DIV ? app_div_reg :
    addr == `PCRC_FRAC ? frac_word :
    addr == `PCRC_WDOG_CFG ? wdog_cfg :
    addr == `PCRC_STATUS ? stat_word : 32'h0000_0000;

  // Read data stand one cycle only
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_data <= 32'h0000_0000;
    end else if (clk_en) begin
      rd_data <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // PLL settings: cleared by full reset only
  always_ff @(posedge clk_sys) begin
    // R15 defined power-up state
    if (!rst_b || (pll_clear && clk_en)) begin
      core_input_scale <= `PCRC_ISCALE_RST;
      core_loop_multiplier <= `PCRC_LMULT_RST;
      core_post_scaler <= `PCRC_POST_RST;
      app_input_scale <= `PCRC_ISCALE_RST;
      app_mult <= `PCRC_LMULT_RST;
      app_post_scaler <= `PCRC_POST_RST;
      app_input_sel <= 1'b0;
      pll_low_power <= 1'b0;
      app_div_reg <= 32'h0000_0000;
      {frac_en, cycle_count, minor_count} <= 17'h00000;
    end else if (clk_en) begin
      // R03 core configuration write
      if (wr_core) begin
        // R01 ratio fields to PLL
        core_input_scale <= wr_data[`PCRC_ISCALE_LSB +: 6];
        core_loop_multiplier <= wr_data[`PCRC_LMULT_LSB +: 13];
        core_post_scaler <= wr_data[`PCRC_POST_LSB +: 3];
        pll_low_power <= wr_data[`PCRC_LOWPWR_BIT];
      end
      // R10 secondary input select
      if (wr_app) begin
        app_input_scale <= wr_data[`PCRC_ISCALE_LSB +: 6];
        app_mult <= wr_data[`PCRC_LMULT_LSB +: 13];
        app_post_scaler <= wr_data[`PCRC_POST_LSB +: 3];
        app_input_sel <= wr_data[`PCRC_INSEL_BIT];
      end
      if (wr_adiv) begin
        app_div_reg <= {wr_data[`PCRC_APPEN_BIT], 19'h00000,
          wr_data[11:0]};
      end
      // R12 fraction control fields
      if (wr_frac) begin
        minor_count <= wr_data[7:0];
        cycle_count <= wr_data[`PCRC_CYCLE_LSB +: 8];
        frac_en <= wr_data[`PCRC_FRACEN_BIT];
      end
    end
  end

  // Non-PLL settings: cleared by any reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b || (in_hold && clk_en)) begin
      clk_div_reg <= 16'h0000;
      wdog_cfg <= 32'h0000_0000;
      cfg_fresh <= 1'b0;
    end else if (clk_en) begin
      // Reload one cycle late, once the new set-up stands
      cfg_fresh <= wr_wcfg;
      if (wr_cdiv) begin
        clk_div_reg <= wr_data[15:0];
      end
      if (wr_wcfg) begin
        wdog_cfg <= {wr_data[`PCRC_WDEN_BIT], 3'h0, wr_data[27:0]};
      end
    end
  end

  // Sticky watchdog flag, event wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wdog_fired <= 1'b0;
    end else if (clk_en) begin
      if (wdog_expire) begin
        wdog_fired <= 1'b1;
      end else if (wr_stat && wr_data[0]) begin
        wdog_fired <= 1'b0;
      end
    end
  end

  // ********************************
  // Fractional multiplier
  // ********************************
  // R11 count period, bump early part
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      frac_cnt <= 8'h00;
      app_loop_multiplier <= `PCRC_LMULT_RST;
    end else if (clk_en) begin
      frac_cnt <= (!frac_en || frac_cnt >= cycle_count) ? 8'h00 :
        frac_cnt + 8'h01;
      // R23 unchanged when disabled
      app_loop_multiplier <= (frac_en && frac_cnt <= minor_count) ?
        app_mult + 13'h0001 : app_mult;
    end
  end

  // ********************************
  // Clock dividers
  // ********************************
  logic app_toggle; // Even-divided app clock
  logic ref_tick_raw; // Reference divider tick

  // R06 core clock divider
  pcrc_clkdiv #(.W(8)) u_core_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .div(clk_div_reg[7:0]), .tick(core_clk_tick), .toggle());
  // R06 switch clock divider
  pcrc_clkdiv #(.W(8)) u_sw_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .div(clk_div_reg[`PCRC_SWDIV_LSB +: 8]), .tick(switch_clk_tick),
    .toggle());
  // R05 fixed reference divider
  pcrc_clkdiv #(.W(8)) u_ref_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .div(`PCRC_REF_DIV), .tick(ref_tick_raw), .toggle());
  // R09 toggle gives even division
  pcrc_clkdiv #(.W(12)) u_app_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .div(app_div_reg[11:0]), .tick(), .toggle(app_toggle));

  // Drive reference and app clock outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ref_clk_tick <= 1'b0;
      app_clock_pin <= 1'b0;
      app_clock_port <= 1'b0;
    end else if (clk_en) begin
      // R07 low power runs from oscillator
      ref_clk_tick <= pll_low_power ? osc_tick : ref_tick_raw;
      // R08 pin and port share one clock
      app_clock_pin <= app_div_reg[`PCRC_APPEN_BIT] & app_toggle;
      app_clock_port <= app_div_reg[`PCRC_APPEN_BIT] & app_toggle;
    end
  end

  // ********************************
  // Watchdog
  // ********************************
  // Kick or fresh set-up restarts the count
  wire wdog_reload = wr_kick || cfg_fresh;
  // R19 watchdog on oscillator edges
  pcrc_wdog u_wdog (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .osc_tick(osc_tick), .enable(wdog_cfg[`PCRC_WDEN_BIT]),
    .prescale(wdog_cfg[15:0]), .timeout(wdog_cfg[`PCRC_WTIMER_LSB +: 12]),
    .kick(wdog_reload), .expire(wdog_expire));

  // ********************************
  // Reset sequencer
  // ********************************
  // Next sequencer state
  always_comb begin
    next_seq = seq;
    case (seq)
      pcrc_pkg::SEQ_RUN: begin
        // R16 reset pin or events hold chip
        if (ext_low || soft_req || wdog_expire) begin
          next_seq = pcrc_pkg::SEQ_HOLD;
        end
      end
      pcrc_pkg::SEQ_HOLD: begin
        if (!ext_low && seq_cnt == 5'h00) begin
          next_seq = pcrc_pkg::SEQ_BOOT;
        end
      end
      pcrc_pkg::SEQ_BOOT: begin
        if (ext_low) begin
          next_seq = pcrc_pkg::SEQ_HOLD;
        end else if (seq_cnt == 5'h00) begin
          next_seq = pcrc_pkg::SEQ_RUN;
        end
      end
      default: begin
        next_seq = pcrc_pkg::SEQ_HOLD;
      end
    endcase
  end

  // Sequencer registers and reset outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      seq <= pcrc_pkg::SEQ_HOLD;
      seq_cnt <= 5'(`PCRC_HOLD_CYC);
      keep_pll <= 1'b0;
      chip_reset_b <= 1'b0;
      pin_pulldown_en <= 1'b1;
      boot_start <= 1'b0;
    end else if (clk_en) begin
      seq <= next_seq;
      // R18 soft reset keeps PLL
      if (seq == pcrc_pkg::SEQ_RUN && next_seq == pcrc_pkg::SEQ_HOLD) begin
        keep_pll <= soft_req && !ext_low && !wdog_expire;
      end else if (ext_low) begin
        keep_pll <= 1'b0;
      end
      if (next_seq != seq) begin
        seq_cnt <= next_seq == pcrc_pkg::SEQ_HOLD ? 5'(`PCRC_HOLD_CYC) :
          5'(`PCRC_BOOT_CYC);
      end else if (seq_cnt != 5'h00) begin
        seq_cnt <= seq_cnt - 5'h01;
      end
      // R15 pull-downs on while held
      chip_reset_b <= next_seq != pcrc_pkg::SEQ_HOLD;
      pin_pulldown_en <= next_seq == pcrc_pkg::SEQ_HOLD;
      // R16 boot starts after delay
      boot_start <= seq == pcrc_pkg::SEQ_BOOT &&
        next_seq == pcrc_pkg::SEQ_RUN;
    end
  end

  // ********************************
  // JTAG reset detector
  // ********************************
  // R17 five TCK edges with TMS high
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tms_cnt <= 3'h0;
      jtag_idle_reset <= 1'b0;
    end else if (clk_en) begin
      jtag_idle_reset <= 1'b0;
      if (tck_rise) begin
        if (!tms_s[1]) begin
          tms_cnt <= 3'h0;
        end else if (tms_cnt == `PCRC_JTAG_TMS_N - 3'h1) begin
          tms_cnt <= 3'h0;
          jtag_idle_reset <= 1'b1;
        end else begin
          tms_cnt <= tms_cnt + 3'h1;
        end
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  sequence core_write_s;
    clk_en && wr_core && !soft_req && seq == pcrc_pkg::SEQ_RUN;
  endsequence
  core_cfg_write_a: assert property ( // R03
    core_write_s |=> core_loop_multiplier == $past(wr_data[18:6]))
    else $error("core multiplier not updated by write");
  frac_off_a: assert property ( // R23
    (clk_en && !frac_en && $stable(app_mult)) [*2] |->
    app_loop_multiplier == app_mult)
    else $error("multiplier changed with fraction off");
  frac_bump_a: assert property ( // R11
    (clk_en && frac_en && !wr_app && frac_cnt == 8'h00) |=>
    app_loop_multiplier == $past(app_mult) + 13'h0001)
    else $error("fraction did not add one");
  sequence soft_hold_s;
    clk_en && soft_req && seq == pcrc_pkg::SEQ_RUN && !ext_low;
  endsequence
  soft_keep_a: assert property ( // R18
    soft_hold_s ##0 !wdog_expire |=> ##1 !chip_reset_b ##0
    $stable(core_loop_multiplier) [*4])
    else $error("soft reset lost PLL setting");
  ext_reset_a: assert property ( // R16
    (clk_en && ext_low) [*2] |=> !chip_reset_b)
    else $error("reset pin did not hold chip");
  boot_start_a: assert property ( // R16
    ($rose(chip_reset_b) && !ext_low) [*1] ##1 (clk_en && !ext_low) [*8]
    |-> ##[BOOT_MIN:BOOT_MAX] (boot_start || !clk_en || ext_low))
    else $error("boot did not start after reset");
  jtag_five_a: assert property ( // R17
    jtag_idle_reset |-> $past(tms_cnt) == `PCRC_JTAG_TMS_N - 3'h1)
    else $error("JTAG reset without five TMS edges");
  low_ref_a: assert property ( // R07
    (clk_en && pll_low_power && !osc_tick) |=> !ref_clk_tick)
    else $error("reference ran at PLL rate in low power");
endmodule // pcrc_top

// File: rtl/pcrc_cfg.svh
// Offsets, field positions, reset values and timing counts for pcrc
`ifndef PCRC_CFG_SVH
`define PCRC_CFG_SVH
// Register offsets (byte addresses)
`define PCRC_CORE_PLL 8'h00
`define PCRC_CLK_DIV 8'h04
`define PCRC_APP_PLL 8'h08
`define PCRC_APP_DIV 8'h0c
`define PCRC_FRAC 8'h10
`define PCRC_WDOG_CFG 8'h14
`define PCRC_WDOG_KICK 8'h18
`define PCRC_STATUS 8'h1c
// PLL word fields
`define PCRC_ISCALE_LSB 0
`define PCRC_LMULT_LSB 6
`define PCRC_POST_LSB 19
`define PCRC_LOWPWR_BIT 22
`define PCRC_INSEL_BIT 23
`define PCRC_SOFT_BIT 31
// Other fields
`define PCRC_SWDIV_LSB 8
`define PCRC_APPEN_BIT 31
`define PCRC_CYCLE_LSB 8
`define PCRC_FRACEN_BIT 31
`define PCRC_WTIMER_LSB 16
`define PCRC_WDEN_BIT 31
// Power-up PLL defaults
`define PCRC_ISCALE_RST 6'h00
`define PCRC_LMULT_RST 13'h0063
`define PCRC_POST_RST 3'h1
// Timing
`define PCRC_CLK_NS 50
`define PCRC_HOLD_NS 500
`define PCRC_BOOT_NS 1000
`define PCRC_HOLD_CYC ((`PCRC_HOLD_NS + `PCRC_CLK_NS - 1) / `PCRC_CLK_NS)
`define PCRC_BOOT_CYC ((`PCRC_BOOT_NS + `PCRC_CLK_NS - 1) / `PCRC_CLK_NS)
`define PCRC_REF_DIV 8'h01
`define PCRC_JTAG_TMS_N 3'h5
`endif

// File: rtl/pcrc_pkg.sv
// Types shared by the clock and reset control block
package pcrc_pkg;
  // Reset sequencer states
  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_BOOT = 2'b10
  } pcrc_seq_t;
endpackage

// File: rtl/pcrc_clkdiv.sv
// Programmable clock divider giving a tick and a toggled clock
`timescale 1ns/100ps
module pcrc_clkdiv #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [W-1:0] div,
  output logic tick,
  output logic toggle
);
  // Position within the divided period
  logic [W-1:0] cnt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Count div+1 enabled cycles, toggle every period
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt <= '0;
      tick <= 1'b0;
      toggle <= 1'b0;
    end else if (clk_en) begin
      if (cnt >= div) begin
        cnt <= '0;
        tick <= 1'b1;
        toggle <= ~toggle;
      end else begin
        cnt <= cnt + 1'b1;
        tick <= 1'b0;
      end
    end
  end

  // R06 divided tick spacing
  tick_spacing_a: assert property ( // R06
    (tick && div != '0 && clk_en) |=> !tick)
    else $error("divider ticked on adjacent cycles");
endmodule // pcrc_clkdiv

// File: rtl/pcrc_wdog.sv
// Watchdog: 16-bit prescaler and 12-bit timer on oscillator edges
`timescale 1ns/100ps
module pcrc_wdog (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic osc_tick,
  input wire logic enable,
  input wire logic [15:0] prescale,
  input wire logic [11:0] timeout,
  input wire logic kick,
  output logic expire
);
  // Prescaler and timer counting down
  logic [15:0] pre;
  logic [11:0] tmr;
  wire at_end = (pre == 16'h0000) && (tmr == 12'h000);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Reload on kick or disable, fire once at zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pre <= 16'h0000;
      tmr <= 12'h000;
      expire <= 1'b0;
    end else if (clk_en) begin
      expire <= 1'b0;
      // R22 reload on kick
      if (kick || !enable) begin
        pre <= prescale;
        tmr <= timeout;
      end else if (osc_tick) begin
        // R20 prescaler then timer
        if (at_end) begin
          expire <= 1'b1;
          pre <= prescale;
          tmr <= timeout;
        end else if (pre == 16'h0000) begin
          pre <= prescale;
          tmr <= tmr - 12'h001;
        end else begin
          pre <= pre - 16'h0001;
        end
      end
    end
  end

  // R19 time-out fires
  wdog_fire_a: assert property ( // R19
    (clk_en && enable && !kick && osc_tick && at_end) |=> expire)
    else $error("watchdog did not fire at zero");
  // R22 kick restarts count
  wdog_kick_a: assert property ( // R22
    (clk_en && enable && kick) |=> (pre == $past(prescale)) && !expire)
    else $error("watchdog kick did not reload");
endmodule // pcrc_wdog

// File: verification/pcrc_osc_model.sv
// Oscillator and reset pin source standing outside the block
`timescale 1ns/100ps
module pcrc_osc_model #(
  parameter int HALF_NS = 200
) (
  input wire logic hold_reset_b,
  output logic osc_input,
  output logic ext_reset_b
);
  // ************
  // Oscillator
  // ************
  // running before release
  initial begin
    osc_input = 1'b0;
    forever #(HALF_NS) osc_input = ~osc_input;
  end
  assign ext_reset_b = hold_reset_b;
endmodule // pcrc_osc_model

// File: verification/pcrc_top_tb.sv
// Self-checking testbench for the clock and reset control block
`timescale 1ns/100ps
`include "pcrc_cfg.svh"
module pcrc_top_tb;
  // ************
  // Signals
  // ************
  logic clk_sys, rst_b, clk_en, wr_en, rd_en, tck, tms, hold_b;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data;
  logic osc_input, ext_reset_b, app_input_sel, pll_low_power;
  logic [5:0] core_input_scale, app_input_scale;
  logic [12:0] core_loop_multiplier, app_loop_multiplier;
  logic [2:0] core_post_scaler, app_post_scaler;
  logic core_clk_tick, switch_clk_tick, ref_clk_tick;
  logic app_clock_pin, app_clock_port, chip_reset_b;
  logic pin_pulldown_en, boot_start, jtag_idle_reset;
  int num_errors, checks_done, n, m;
  pcrc_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .osc_input(osc_input), .ext_reset_b(ext_reset_b),
    .tck(tck), .tms(tms), .core_input_scale(core_input_scale),
    .core_loop_multiplier(core_loop_multiplier),
    .core_post_scaler(core_post_scaler),
    .app_input_scale(app_input_scale),
    .app_loop_multiplier(app_loop_multiplier),
    .app_post_scaler(app_post_scaler), .app_input_sel(app_input_sel),
    .pll_low_power(pll_low_power), .core_clk_tick(core_clk_tick),
    .switch_clk_tick(switch_clk_tick), .ref_clk_tick(ref_clk_tick),
    .app_clock_pin(app_clock_pin), .app_clock_port(app_clock_port),
    .chip_reset_b(chip_reset_b), .pin_pulldown_en(pin_pulldown_en),
    .boot_start(boot_start), .jtag_idle_reset(jtag_idle_reset));
  pcrc_osc_model osc (.hold_reset_b(hold_b), .osc_input(osc_input),
    .ext_reset_b(ext_reset_b));
  // Clock at 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ************
  // Tasks
  // ************
  // Compare one value, count and report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // Read strobe, data checked in the following cycle under a mask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] mk);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    cmp(rd_data & mk, e);
  endtask
  // Count high samples of a tick, or of a multiplier match, over a window
  task automatic ticks(input int sel, input int len, output int c);
    c = 0;
    repeat (len) begin
      @(negedge clk_sys);
      case (sel)
        0: c += int'(core_clk_tick);
        1: c += int'(switch_clk_tick);
        2: c += int'(ref_clk_tick);
        3: c += int'(app_loop_multiplier === 13'h000b);
        default: c += int'(app_loop_multiplier === 13'h000a);
      endcase
    end
  endtask
  // Bounded wait for the chip to enter reset
  task automatic wait_rst(input int lim);
    n = 0;
    while (chip_reset_b !== 1'b0 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    cmp(32'(chip_reset_b), 32'h0);
    if (chip_reset_b !== 1'b0)
      summarize();
  endtask
  // Bounded wait for the boot pulse
  task automatic wait_boot();
    n = 0;
    while (boot_start !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    cmp(32'(boot_start), 32'h1);
    cmp(32'({chip_reset_b, pin_pulldown_en}), 32'h2);
    if (boot_start !== 1'b1)
      summarize();
  endtask
  // Core PLL fields as one word
  function automatic logic [31:0] core_w();
    return {10'h000, core_post_scaler, core_loop_multiplier,
            core_input_scale};
  endfunction
  // Counts and verdict, then end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    {rst_b, wr_en, rd_en, tck, tms, addr, wr_data} = '0;
    {clk_en, hold_b} = 2'b11;
    num_errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp(32'(pin_pulldown_en), 32'h1);
    cmp(32'(chip_reset_b), 32'h0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_boot();
    rd(`PCRC_CORE_PLL, 32'h000818c0, 32'h00ffffff);
    rd(8'h20, 32'h0, 32'hffffffff);
    $display("test reset done");
    wr(`PCRC_CORE_PLL, 32'h00107fc3);
    @(negedge clk_sys);
    cmp(core_w(), 32'h00107fc3);
    rd(`PCRC_CORE_PLL, 32'h00107fc3, 32'h00ffffff);
    wr(`PCRC_CLK_DIV, 32'h00000301);
    ticks(0, 40, m);
    cmp(32'(m), 32'd20);
    ticks(1, 40, m);
    cmp(32'(m), 32'd10);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(`PCRC_CLK_DIV, 32'h00000000);
    clk_en <= 1'b1;
    ticks(0, 40, m);
    cmp(32'(m), 32'd20);
    ticks(2, 40, m);
    cmp(32'(m), 32'd20);
    wr(`PCRC_CORE_PLL, 32'h00507fc3);
    @(negedge clk_sys);
    cmp(32'(pll_low_power), 32'h1);
    ticks(2, 80, m);
    cmp(32'(m), 32'd10);
    wr(`PCRC_CORE_PLL, 32'h00107fc3);
    $display("test core clocks done");
    wr(`PCRC_APP_PLL, 32'h00900281);
    rd(`PCRC_APP_PLL, 32'h00900281, 32'hffffffff);
    wr(`PCRC_FRAC, 32'h80000300);
    @(negedge clk_sys);
    cmp(32'(app_input_sel), 32'h1);
    cmp(32'({app_post_scaler, app_input_scale}), 32'h81);
    ticks(3, 40, m);
    cmp(32'(m), 32'd10);
    wr(`PCRC_FRAC, 32'h0);
    repeat (2) @(negedge clk_sys);
    ticks(4, 40, m);
    cmp(32'(m), 32'd40);
    wr(`PCRC_APP_DIV, 32'h80000001);
    repeat (2) @(negedge clk_sys);
    m = 0;
    n = 0;
    repeat (40) begin
      logic p;
      p = app_clock_pin;
      @(negedge clk_sys);
      m += int'(p === 1'b0 && app_clock_pin === 1'b1);
      n += int'(app_clock_pin !== app_clock_port);
    end
    cmp(32'(m), 32'd10);
    cmp(32'(n), 32'd0);
    $display("test app clock done");
    @(posedge clk_sys);
    tms <= 1'b1;
    // Fifth rise ends the loop so the pulse falls in the window
    repeat (5) begin
      repeat (4) @(posedge clk_sys);
      tck <= 1'b0;
      repeat (4) @(posedge clk_sys);
      tck <= 1'b1;
    end
    m = 0;
    repeat (20) begin
      @(negedge clk_sys);
      m += int'(jtag_idle_reset === 1'b1);
    end
    cmp(32'(m), 32'd1);
    @(posedge clk_sys);
    tck <= 1'b0;
    $display("test jtag done");
    wr(`PCRC_CORE_PLL, 32'h80107fc3);
    wait_rst(4);
    wait_boot();
    cmp(core_w(), 32'h00107fc3);
    rd(`PCRC_STATUS, 32'h2, 32'h2);
    $display("test soft reset done");
    wr(`PCRC_WDOG_CFG, 32'h80030001);
    repeat (4) begin
      repeat (30) @(posedge clk_sys);
      wr(`PCRC_WDOG_KICK, 32'h0);
    end
    cmp(32'(chip_reset_b), 32'h1);
    rd(`PCRC_STATUS, 32'h0, 32'h1);
    wr(`PCRC_WDOG_CFG, 32'h80010001);
    wait_rst(200);
    wait_boot();
    cmp(core_w(), 32'h000818c0);
    rd(`PCRC_STATUS, 32'h1, 32'h1);
    wr(`PCRC_STATUS, 32'h1);
    rd(`PCRC_STATUS, 32'h0, 32'h1);
    $display("test watchdog done");
    @(posedge clk_sys);
    hold_b <= 1'b0;
    wait_rst(10);
    repeat (20) @(posedge clk_sys);
    cmp(32'(chip_reset_b), 32'h0);
    hold_b <= 1'b1;
    wait_boot();
    $display("test reset pin done");
    summarize();
  end
endmodule // pcrc_top_tb
